// ### pkg/uart_sc_pkg.sv
// Purpose: shared constants and types for the smart-card / bus-collision uart
// Assumes: 32-bit classic wishbone, byte addresses, one word per register
// Notes: control and status layouts are packed structs, lowest field last
package uart_sc_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_BAUD = 8'h04;
  localparam logic [7:0] ADDR_TXBUF = 8'h08;
  localparam logic [7:0] ADDR_RXBUF = 8'h0C;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  // serial mode codes
  localparam logic [2:0] MODE_BUS = 3'h6;
  localparam logic [2:0] MODE_CARD = 3'h5;
  // prescaler selects and their count masks
  localparam logic [1:0] PRE_F1 = 2'h0;
  localparam logic [1:0] PRE_F2 = 2'h1;
  localparam logic [1:0] PRE_F8 = 2'h2;
  localparam logic [4:0] MASK_F1 = 5'h00;
  localparam logic [4:0] MASK_F2 = 5'h01;
  localparam logic [4:0] MASK_F8 = 5'h07;
  localparam logic [4:0] MASK_F32 = 5'h1F;
  // sixteen sub-ticks per bit
  localparam logic [3:0] SUB_MID = 4'h7;
  localparam logic [3:0] SUB_LAST = 4'hF;
  // start + 8 data + 1 stop
  localparam logic [3:0] BASE_BITS = 4'hA;
  localparam logic [3:0] ONE_BIT = 4'h1;
  localparam logic [3:0] TWO_BITS = 4'h2;
  localparam logic [7:0] BAUD_RESET = 8'h00;
  localparam int STAT_W = 8;

  typedef struct packed {
    logic stop2;
    logic parity_en;
    logic collision_en_ch1;
    logic collision_en_ch0;
    logic start_cond_sel;
    logic tx_enable_autoclear;
    logic collision_sample_sel;
    logic data_invert_sel;
    logic bit_order_sel;
    logic parity_sense_sel;
    logic err_signal_en;
    logic tx_int_cause_sel;
    logic rx_allow;
    logic tx_allow;
    logic [1:0] presc_sel;
    logic clock_src_sel;
    logic [2:0] serial_mode_field;
  } ctrl_t;

  typedef struct packed {
    logic collision_flag;
    logic error_any_flag;
    logic parity_err_flag;
    logic frame_err_flag;
    logic overrun_flag;
    logic rx_full;
    logic tx_idle;
    logic tx_buf_empty;
  } stat_t;

  localparam int CTRL_W = $bits(ctrl_t);
  localparam ctrl_t CTRL_RESET = '0;

  // data bits in line order: optional msb-first, optional inversion
  function automatic logic [7:0] line_map(input logic [7:0] d, input logic rev,
                                          input logic inv);
    logic [7:0] r;
    r = d;
    if (rev) begin
      r = {<<{d}};
    end
    return inv ? ~r : r;
  endfunction
endpackage

// ### logic/uart_sc.sv
// Purpose: uart channel with smart-card and bus-collision modes, wishbone slave
// Assumes: one 100 MHz clock, synchronous active-high reset
// Notes: serial_in / serial_out are tied together off chip with a pull-up
//
// Overview of operation
// - bus mode: each protocol bit is one whole async character frame.
// - transmitted level differing from received level raises a collision request.
// - collision_sample_sel picks mid-bit or end-of-bit comparison instant.
// - autoclear drops tx_allow on collision; start_cond_sel picks transmit start trigger.
// - channels 0 and 1 detect collisions only with their enable bits set.
// - smart-card mode: direct or inverse convention, line pulled low on parity error.
// - internal clock rate is prescaled clock over 16 times (divider plus one).
// - external clock rate is clock-pin frequency over 16 times (divider plus one).
// - transmit starts only with tx_allow set and transmit buffer full.
// - receive starts only with rx_allow set and a start bit seen.
// - smart-card transmit request comes half a bit after the shift register finishes, cause select set.
// - receive request comes when a character moves into the receive buffer.
// - overrun set at bit before last stop if unread; buffer kept, no request.
// - frame_err_flag set when configured stop bits are missing.
// - error_any_flag set whenever overrun, framing or parity error flagged.
// - parity error signalling on the line only with err_signal_en set.
// - parity error holds serial_out low; buffer read clears flag and releases line.
// - smart-card transmit-finished request half a bit after the stop bit; bus mode at its end.
// - direct: parity even, lsb first, plain; inverse: odd, msb first, inverted.
`timescale 1ns/1ns
module uart_sc #(
  parameter int CHANNEL = 2 // 0 and 1 need their collision enable bit
) (
  input wire logic clock, // system clock
  input wire logic rst, // synchronous reset, active high
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte enables
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  input wire logic serial_in, // receive pin
  output logic serial_out, // transmit pin
  input wire logic ext_clk, // external transfer clock pin
  output logic tx_req, // transmit request pulse
  output logic rx_req, // receive request pulse
  output logic coll_req // collision request pulse
);
  typedef enum logic [1:0] {TX_IDLE, TX_RUN, TX_TAIL} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} rx_state_t;

  uart_sc_pkg::ctrl_t ctrl_reg, ctrl_next;
  uart_sc_pkg::stat_t stat;
  logic [7:0] baud_reg;
  logic [2:0] sin_sync_reg, eck_sync_reg;
  logic sin_reg, sin_prev_reg, eck_reg, eck_prev_reg;
  logic [4:0] pre_cnt_reg;
  logic [7:0] brg_cnt_reg;
  tx_state_t tx_state_reg;
  rx_state_t rx_state_reg;
  logic [11:0] tx_sh_reg;
  logic [3:0] tx_idx_reg, tx_sub_reg, rx_idx_reg, rx_sub_reg;
  logic [7:0] tx_buf_reg, rx_buf_reg;
  logic tx_empty_reg, rx_full_reg, ovr_pend_reg, err_hold_reg;
  logic ovr_reg, frm_reg, par_reg, coll_flag_reg, err_any_reg;
  logic [11:0] rx_bits_reg;

  // pin synchronisers: level accepted once stages two and three agree
  always_ff @(posedge clock) begin
    if (rst) begin
      sin_sync_reg <= 3'h7;
      eck_sync_reg <= 3'h0;
      sin_reg <= 1'b1;
      sin_prev_reg <= 1'b1;
      eck_reg <= 1'b0;
      eck_prev_reg <= 1'b0;
    end else begin
      sin_sync_reg <= {sin_sync_reg[1:0], serial_in};
      eck_sync_reg <= {eck_sync_reg[1:0], ext_clk};
      if (sin_sync_reg[1] == sin_sync_reg[2]) sin_reg <= sin_sync_reg[2];
      if (eck_sync_reg[1] == eck_sync_reg[2]) eck_reg <= eck_sync_reg[2];
      sin_prev_reg <= sin_reg;
      eck_prev_reg <= eck_reg;
    end
  end

  // mode decode and frame shape
  wire bus_mode = ctrl_reg.serial_mode_field == uart_sc_pkg::MODE_BUS;
  wire card_mode = ctrl_reg.serial_mode_field == uart_sc_pkg::MODE_CARD;
  wire active = bus_mode | card_mode;
  wire par_on = card_mode | ctrl_reg.parity_en;
  wire two_stop = !card_mode & ctrl_reg.stop2;
  wire [3:0] frame_len = uart_sc_pkg::BASE_BITS + {3'h0, par_on} + {3'h0, two_stop};

  // bit clock: prescaled system clock or external edge, then divide by n+1
  wire [4:0] pre_mask = (ctrl_reg.presc_sel == uart_sc_pkg::PRE_F1) ? uart_sc_pkg::MASK_F1 :
                        (ctrl_reg.presc_sel == uart_sc_pkg::PRE_F2) ? uart_sc_pkg::MASK_F2 :
                        (ctrl_reg.presc_sel == uart_sc_pkg::PRE_F8) ? uart_sc_pkg::MASK_F8 :
                        uart_sc_pkg::MASK_F32;
  wire int_tick = (pre_cnt_reg & pre_mask) == pre_mask;
  wire ext_tick = eck_reg & !eck_prev_reg;
  wire src_tick = ctrl_reg.clock_src_sel ? ext_tick : int_tick;
  wire tick16 = src_tick & (brg_cnt_reg == 8'h00);

  always_ff @(posedge clock) begin
    if (rst) begin
      pre_cnt_reg <= 5'h00;
      brg_cnt_reg <= 8'h00;
    end else begin
      pre_cnt_reg <= pre_cnt_reg + 5'h01;
      if (src_tick) brg_cnt_reg <= tick16 ? baud_reg : brg_cnt_reg - 8'h01;
    end
  end

  // bus decode; request taken once, answered on the next edge
  wire req = wb_cyc_i & wb_stb_i & !wb_ack_o;
  wire wr = req & wb_we_i;
  wire rd = req & !wb_we_i;
  wire hit_ctrl = wb_adr_i == uart_sc_pkg::ADDR_CTRL;
  wire hit_baud = wb_adr_i == uart_sc_pkg::ADDR_BAUD;
  wire hit_tx = wb_adr_i == uart_sc_pkg::ADDR_TXBUF;
  wire hit_rx = wb_adr_i == uart_sc_pkg::ADDR_RXBUF;
  wire hit_stat = wb_adr_i == uart_sc_pkg::ADDR_STAT;
  wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire rx_read = rd & hit_rx;
  localparam int STAT_COLL = uart_sc_pkg::STAT_W - 1;
  wire coll_clr = wr & hit_stat & wb_sel_i[0] & wb_dat_i[STAT_COLL];

  // transmitter
  wire [7:0] tx_line = uart_sc_pkg::line_map(tx_buf_reg, ctrl_reg.bit_order_sel,
                                             ctrl_reg.data_invert_sel);
  wire tx_par = ^tx_line ^ !ctrl_reg.parity_sense_sel;
  wire [11:0] tx_frame = {2'h3, par_on ? tx_par : 1'b1, tx_line, 1'b0};
  wire start_ok = !ctrl_reg.start_cond_sel | (rx_state_reg == RX_START);
  wire tx_go = (tx_state_reg == TX_IDLE) & ctrl_reg.tx_allow & !tx_empty_reg & active
               & start_ok;
  wire tx_bit_end = (tx_state_reg == TX_RUN) & tick16 & (tx_sub_reg == uart_sc_pkg::SUB_LAST);
  wire tx_last = tx_bit_end & (tx_idx_reg == frame_len - uart_sc_pkg::ONE_BIT);
  wire tail_end = (tx_state_reg == TX_TAIL) & tick16 & (tx_sub_reg == uart_sc_pkg::SUB_MID);
  wire tx_done = card_mode ? tail_end : tx_last;
  wire tx_req_next = ctrl_reg.tx_int_cause_sel ? tx_done : tx_go;

  // collision compare at the chosen instant of each sent bit
  wire [3:0] coll_pt = ctrl_reg.collision_sample_sel ? uart_sc_pkg::SUB_LAST :
                       uart_sc_pkg::SUB_MID;
  wire coll_ok = (CHANNEL >= 2) | ((CHANNEL == 0) ? ctrl_reg.collision_en_ch0 :
                 ctrl_reg.collision_en_ch1);
  wire collision = bus_mode & coll_ok & (tx_state_reg == TX_RUN) & tick16
                   & (tx_sub_reg == coll_pt) & (serial_out != sin_reg);

  always_ff @(posedge clock) begin
    if (rst) begin
      tx_state_reg <= TX_IDLE;
      tx_sh_reg <= 12'hFFF;
      tx_idx_reg <= 4'h0;
      tx_sub_reg <= 4'h0;
    end else begin
      case (tx_state_reg)
        TX_IDLE: begin
          if (tx_go) begin
            tx_state_reg <= TX_RUN;
            tx_sh_reg <= tx_frame;
            tx_idx_reg <= 4'h0;
            tx_sub_reg <= 4'h0;
          end
        end
        TX_RUN: begin
          if (tick16) tx_sub_reg <= tx_sub_reg + 4'h1;
          if (tx_bit_end) begin
            tx_sh_reg <= {1'b1, tx_sh_reg[11:1]};
            tx_idx_reg <= tx_idx_reg + 4'h1;
          end
          if (tx_last) tx_state_reg <= card_mode ? TX_TAIL : TX_IDLE;
        end
        TX_TAIL: begin
          if (tick16) tx_sub_reg <= tx_sub_reg + 4'h1;
          if (tail_end) tx_state_reg <= TX_IDLE;
        end
        default: tx_state_reg <= TX_IDLE;
      endcase
    end
  end

  // receiver
  wire rx_fall = sin_prev_reg & !sin_reg;
  wire rx_samp = (rx_state_reg == RX_DATA) & tick16 & (rx_sub_reg == uart_sc_pkg::SUB_LAST);
  wire rx_prelast = rx_samp & (rx_idx_reg == frame_len - uart_sc_pkg::TWO_BITS);
  wire rx_last = rx_samp & (rx_idx_reg == frame_len - uart_sc_pkg::ONE_BIT);
  wire [7:0] rx_line = rx_bits_reg[8:1];
  wire [7:0] rx_data = uart_sc_pkg::line_map(rx_line, ctrl_reg.bit_order_sel,
                                             ctrl_reg.data_invert_sel);
  wire rx_par_bad = par_on & ((^rx_line ^ !ctrl_reg.parity_sense_sel) != rx_bits_reg[9]);
  wire rx_frm_bad = !sin_reg | (two_stop & !rx_bits_reg[rx_idx_reg - 4'h1]);
  wire rx_store = rx_last & !ovr_pend_reg;

  always_ff @(posedge clock) begin
    if (rst) begin
      rx_state_reg <= RX_IDLE;
      rx_sub_reg <= 4'h0;
      rx_idx_reg <= 4'h0;
      rx_bits_reg <= 12'h000;
      ovr_pend_reg <= 1'b0;
    end else begin
      case (rx_state_reg)
        RX_IDLE: begin
          // our own error signal on the tied line must not look like a start bit
          if (ctrl_reg.rx_allow & active & rx_fall & !err_hold_reg) begin
            rx_state_reg <= RX_START;
            rx_sub_reg <= 4'h0;
          end
        end
        RX_START: begin
          if (tick16) rx_sub_reg <= rx_sub_reg + 4'h1;
          if (tick16 & (rx_sub_reg == uart_sc_pkg::SUB_MID)) begin
            rx_state_reg <= sin_reg ? RX_IDLE : RX_DATA; // false start rejected
            rx_sub_reg <= 4'h0;
            rx_idx_reg <= 4'h1;
            ovr_pend_reg <= 1'b0;
          end
        end
        RX_DATA: begin
          if (tick16) rx_sub_reg <= rx_sub_reg + 4'h1;
          if (rx_samp) begin
            rx_bits_reg[rx_idx_reg] <= sin_reg;
            rx_idx_reg <= rx_idx_reg + 4'h1;
          end
          if (rx_prelast) ovr_pend_reg <= rx_full_reg;
          if (rx_last) rx_state_reg <= RX_IDLE;
        end
        default: rx_state_reg <= RX_IDLE;
      endcase
    end
  end

  // flags: a set in the same cycle as a clear wins
  wire ovr_next = rx_prelast & rx_full_reg | (ovr_reg & !rx_read);
  wire frm_next = rx_last & rx_frm_bad | (frm_reg & !rx_read);
  wire par_set = rx_last & rx_par_bad;
  wire par_next = par_set | (par_reg & !rx_read);
  wire hold_set = par_set & card_mode & ctrl_reg.err_signal_en;
  localparam int CTRL_W = uart_sc_pkg::CTRL_W;

  always_comb begin
    ctrl_next = uart_sc_pkg::ctrl_t'((ctrl_reg & ~wmask[CTRL_W-1:0])
                                     | (wb_dat_i[CTRL_W-1:0] & wmask[CTRL_W-1:0]));
    if (!(wr & hit_ctrl)) ctrl_next = ctrl_reg;
    if (collision & ctrl_reg.tx_enable_autoclear) ctrl_next.tx_allow = 1'b0;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_reg <= uart_sc_pkg::CTRL_RESET;
      baud_reg <= uart_sc_pkg::BAUD_RESET;
      tx_buf_reg <= 8'h00;
      tx_empty_reg <= 1'b1;
      rx_buf_reg <= 8'h00;
      rx_full_reg <= 1'b0;
      ovr_reg <= 1'b0;
      frm_reg <= 1'b0;
      par_reg <= 1'b0;
      err_any_reg <= 1'b0;
      coll_flag_reg <= 1'b0;
      err_hold_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      if (wr & hit_baud & wb_sel_i[0]) baud_reg <= wb_dat_i[7:0];
      if (wr & hit_tx & wb_sel_i[0]) tx_buf_reg <= wb_dat_i[7:0];
      tx_empty_reg <= (wr & hit_tx & wb_sel_i[0]) ? 1'b0 : (tx_go | tx_empty_reg);
      if (rx_store) rx_buf_reg <= rx_data;
      rx_full_reg <= rx_store | (rx_full_reg & !rx_read);
      ovr_reg <= ovr_next;
      frm_reg <= frm_next;
      par_reg <= par_next;
      err_any_reg <= ovr_next | frm_next | par_next;
      coll_flag_reg <= collision | (coll_flag_reg & !coll_clr);
      err_hold_reg <= hold_set | (err_hold_reg & !rx_read);
    end
  end

  // read mux; unmapped addresses read zero and still acknowledge
  assign stat = '{collision_flag: coll_flag_reg, error_any_flag: err_any_reg,
                  parity_err_flag: par_reg, frame_err_flag: frm_reg, overrun_flag: ovr_reg,
                  rx_full: rx_full_reg, tx_idle: tx_state_reg == TX_IDLE,
                  tx_buf_empty: tx_empty_reg};
  wire [31:0] rd_data = hit_ctrl ? {{(32 - CTRL_W){1'b0}}, ctrl_reg} :
                        hit_baud ? {24'h000000, baud_reg} :
                        hit_tx ? {24'h000000, tx_buf_reg} :
                        hit_rx ? {24'h000000, rx_buf_reg} :
                        hit_stat ? {24'h000000, stat} : 32'h00000000;
  // line held low during an error signal so the far end sees it
  wire sout_next = !err_hold_reg & ((tx_state_reg == TX_RUN) ? tx_sh_reg[0] : 1'b1);

  // all outputs registered
  always_ff @(posedge clock) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      serial_out <= 1'b1;
      tx_req <= 1'b0;
      rx_req <= 1'b0;
      coll_req <= 1'b0;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= rd ? rd_data : 32'h00000000;
      serial_out <= sout_next;
      tx_req <= tx_req_next;
      rx_req <= rx_store;
      coll_req <= collision;
    end
  end

  // helper: cycles between bit ticks, valid once config is steady
  logic [13:0] gap_reg;
  logic steady_reg;
  always_ff @(posedge clock) begin
    if (rst) begin
      gap_reg <= 14'h0001;
      steady_reg <= 1'b0;
    end else begin
      gap_reg <= tick16 ? 14'h0001 : gap_reg + 14'h0001;
      steady_reg <= !(wr & (hit_ctrl | hit_baud)) & (steady_reg | tick16);
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_baud_gap: assert property (tick16 && steady_reg && !ctrl_reg.clock_src_sel
    && ctrl_reg.presc_sel == uart_sc_pkg::PRE_F1 |-> gap_reg == {6'h00, baud_reg} + 14'h0001)
    else $error("bit tick spacing differs from divider plus one");
  a_tx_start_cond: assert property ($rose(tx_state_reg == TX_RUN) |->
    $past(ctrl_reg.tx_allow) && !$past(tx_empty_reg))
    else $error("transmit started without permission or data");
  a_rx_start_cond: assert property ($rose(rx_state_reg == RX_START) |->
    $past(ctrl_reg.rx_allow))
    else $error("receive started while not allowed");
  a_coll_gate: assert property (coll_req |-> bus_mode && coll_ok)
    else $error("collision flagged outside enabled bus mode");
  a_coll_autoclr: assert property (coll_req && $past(ctrl_reg.tx_enable_autoclear)
    |-> !ctrl_reg.tx_allow)
    else $error("transmit enable not cleared on collision");
  a_ovr_no_req: assert property (rx_last && ovr_pend_reg |=> !rx_req && rx_full_reg)
    else $error("overrun character still reported");
  a_err_any_set: assert property ($rose(par_reg) || $rose(frm_reg) || $rose(ovr_reg)
    |-> err_any_reg)
    else $error("error sum not set with its error");
  a_err_line_low: assert property ($rose(err_hold_reg) |=> !serial_out [*2])
    else $error("line not held low on parity error");
  a_err_needs_en: assert property ($rose(err_hold_reg) |-> $past(ctrl_reg.err_signal_en))
    else $error("error signal without enable");
  a_err_release: assert property (err_hold_reg && rx_read && !hold_set
    |=> !err_hold_reg && !par_reg ##1 serial_out)
    else $error("buffer read did not release line");
  a_tail_req: assert property (tail_end && ctrl_reg.tx_int_cause_sel |=> tx_req)
    else $error("finish request missing after stop bit");

  c_card_tx: cover property (card_mode && tx_req);
  c_collision: cover property (coll_req);
  c_rx_parity: cover property ($rose(err_hold_reg));
  c_overrun: cover property ($rose(ovr_reg));
endmodule // uart_sc

// ### tb/card_model.sv
// Purpose: card on the shared data line, sends and decodes characters
// Assumes: line is wired-and of both drivers with a pull-up
// Notes: bit length in clocks is set by the bench to match the divider
`timescale 1ns/1ns
module card_model (
  input wire logic clock, // system clock
  input wire logic serial_out, // device transmit pin
  output logic line, // shared line seen by both
  output logic [7:0] got_byte, // decoded character
  output logic got_valid // one-cycle strobe per character
);
  logic drv = 1'b1;
  logic hold_low = 1'b0;
  logic sending = 1'b0;
  logic listen = 1'b0;
  logic inv = 1'b0;
  logic nack = 1'b0;
  logic [7:0] b = 8'h00;
  int bitlen = 16;
  initial got_valid = 1'b0;
  initial got_byte = 8'h00;
  // released means pulled high, so no stale level survives
  assign line = serial_out & drv & ~hold_low;
  // direct convention only: even parity, lsb first
  task automatic send(input logic [7:0] d, input logic bad_par, input logic bad_stop);
    logic [10:0] fr;
    // let a character still on the line finish before the next one starts
    for (int n = 0; n < 400 && sending; n++) @(posedge clock);
    fr = {~bad_stop, ^d ^ bad_par, d, 1'b0};
    sending = 1'b1;
    for (int i = 0; i < 11; i++) begin
      drv <= fr[i];
      repeat (bitlen) @(posedge clock);
    end
    drv <= 1'b1;
    sending = 1'b0;
  endtask
  // mid-bit sampling; parity is not judged here
  always begin
    @(negedge line);
    if (listen && !sending) begin
      repeat (bitlen / 2) @(posedge clock);
      for (int i = 0; i < 8; i++) begin
        repeat (bitlen) @(posedge clock);
        if (inv) b[7 - i] = ~line;
        else b[i] = line;
      end
      repeat (2 * bitlen) @(posedge clock);
      got_byte <= b;
      got_valid <= 1'b1;
      @(posedge clock);
      got_valid <= 1'b0;
      if (nack) begin
        // report an error by pulling the line low after the stop bit
        repeat (bitlen / 2) @(posedge clock);
        drv <= 1'b0;
        repeat (bitlen) @(posedge clock);
        drv <= 1'b1;
      end
    end
  end
endmodule // card_model

// ### tb/uart_sc_tb.sv
// Purpose: self-checking bench for the smart-card / collision uart
// Assumes: wishbone answers one cycle after the request is taken
// Notes: reads are noted in a queue and judged by a monitor process
`timescale 1ns/1ns
module uart_sc_tb;
  typedef struct packed {logic [31:0] val; logic [31:0] mask;} note_t;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack, serial_out, tx_req, rx_req, coll_req, line, got_valid;
  logic [7:0] got_byte;
  note_t rd_q[$];
  logic [7:0] byte_q[$];
  int err_total = 0;
  int samples_checked = 0;
  logic [31:0] seed = 32'h1C12D143;
  uart_sc_pkg::ctrl_t c;
  logic [1:0] ext_div = 2'h0;
  always #5 clock = ~clock;
  // external transfer clock pin: one rising edge every four clocks
  always @(posedge clock) ext_div <= ext_div + 2'h1;
  uart_sc #(.CHANNEL(0)) uart_sc_i (.clock(clock), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .serial_in(line), .serial_out(serial_out), .ext_clk(ext_div[1]),
    .tx_req(tx_req), .rx_req(rx_req), .coll_req(coll_req));
  card_model card_model_i (.clock(clock), .serial_out(serial_out), .line(line),
    .got_byte(got_byte), .got_valid(got_valid));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("errors %0d checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // classic cycle: hold everything until ack is sampled, then release
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    {cyc, stb, we, adr, wdat, sel} <= {1'b1, 1'b1, w, a, d, 4'hF};
    for (n = 0; n < 20 && ack !== 1'b1; n++) @(posedge clock);
    if (n == 20) begin
      err_total++;
      stop_test();
    end
    {cyc, stb, we} <= 3'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
    rd_q.push_back('{v, m});
    bus(1'b0, a, 32'h0);
  endtask
  task automatic set_ctrl();
    bus(1'b1, uart_sc_pkg::ADDR_CTRL, 32'(c));
  endtask
  // k: 0 transmit, 1 receive, 2 collision
  task automatic wait_req(input int k, input int lim);
    int n;
    logic [2:0] r;
    for (n = 0; n < lim; n++) begin
      @(posedge clock);
      r = {coll_req, rx_req, tx_req};
      if (r[k] === 1'b1) break;
    end
    check("request", 32'h1, 32'(n < lim));
    if (n == lim) stop_test();
  endtask
  task automatic wait_pin(input logic v, input int lim);
    for (int n = 0; n < lim && serial_out !== v; n++) @(posedge clock);
    check("serial_out", 32'(v), 32'(serial_out));
  endtask
  // monitor: oldest note against each read answer
  always @(posedge clock) begin
    note_t nt;
    if (ack === 1'b1 && we === 1'b0) begin
      nt = rd_q.pop_front();
      check("read data", nt.val, rdat & nt.mask);
    end
    if (got_valid === 1'b1) check("line byte", 32'(byte_q.pop_front()), 32'(got_byte));
  end
  initial begin
    repeat (100000) @(posedge clock);
    err_total++;
    stop_test();
  end
  initial begin
    int conv;
    logic [7:0] d;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    rd(uart_sc_pkg::ADDR_CTRL, 32'h0, 32'hFFFFFFFF);
    rd(uart_sc_pkg::ADDR_BAUD, 32'h0, 32'hFFFFFFFF);
    rd(uart_sc_pkg::ADDR_STAT, 32'h1, 32'h1);
    rd(8'h1C, 32'h0, 32'hFFFFFFFF);
    // both conventions; second at half the rate, third on the external pin clock
    for (conv = 0; conv < 3; conv++) begin
      c = '0;
      c.serial_mode_field = uart_sc_pkg::MODE_CARD;
      c.tx_int_cause_sel = 1'b1;
      c.clock_src_sel = conv[1];
      {c.parity_sense_sel, c.bit_order_sel, c.data_invert_sel} = {!conv[0], conv[0], conv[0]};
      set_ctrl(); // requests are pulses, nothing stays pending
      bus(1'b1, uart_sc_pkg::ADDR_BAUD, 32'(conv[0]));
      card_model_i.bitlen = (conv == 2) ? 64 : 16 * (conv + 1);
      {card_model_i.inv, card_model_i.nack, card_model_i.listen} = {conv[0], conv[0], 1'b1};
      d = 8'(rnd());
      byte_q.push_back(d);
      bus(1'b1, uart_sc_pkg::ADDR_TXBUF, {24'h0, d});
      repeat (40) @(posedge clock);
      check("idle line", 32'h1, 32'(serial_out));
      c.tx_allow = 1'b1;
      set_ctrl();
      wait_req(0, 1600);
      if (conv == 1) check("returned level", 32'h0, 32'(line));
      repeat (40) @(posedge clock);
      card_model_i.listen = 1'b0;
    end
    bus(1'b1, uart_sc_pkg::ADDR_BAUD, 32'h0);
    card_model_i.bitlen = 16;
    c = '0;
    c.serial_mode_field = uart_sc_pkg::MODE_CARD;
    {c.rx_allow, c.parity_sense_sel, c.err_signal_en} = 3'h7;
    set_ctrl();
    d = 8'(rnd());
    fork card_model_i.send(d, 1'b0, 1'b0); join_none
    wait_req(1, 400);
    rd(uart_sc_pkg::ADDR_RXBUF, {24'h0, d}, 32'hFF);
    // third character arrives while the second is unread
    d = 8'(rnd());
    fork card_model_i.send(d, 1'b0, 1'b0); join_none
    wait_req(1, 400);
    card_model_i.send(~d, 1'b0, 1'b0);
    repeat (30) @(posedge clock);
    rd(uart_sc_pkg::ADDR_STAT, 32'h48, 32'h58);
    rd(uart_sc_pkg::ADDR_RXBUF, {24'h0, d}, 32'hFF);
    card_model_i.send(8'(rnd()), 1'b1, 1'b0);
    wait_pin(1'b0, 100);
    rd(uart_sc_pkg::ADDR_STAT, 32'h60, 32'h60);
    rd(uart_sc_pkg::ADDR_RXBUF, 32'h0, 32'h0);
    wait_pin(1'b1, 3);
    rd(uart_sc_pkg::ADDR_STAT, 32'h0, 32'h60);
    // bad parity and missing stop bit with error signalling off
    c.err_signal_en = 1'b0;
    set_ctrl();
    card_model_i.send(8'(rnd()), 1'b1, 1'b1);
    repeat (30) @(posedge clock);
    rd(uart_sc_pkg::ADDR_STAT, 32'h70, 32'h70);
    check("serial_out", 32'h1, 32'(serial_out));
    rd(uart_sc_pkg::ADDR_RXBUF, 32'h0, 32'h0);
    // bus mode: line held low by the far side collides with ones
    c = '0;
    c.serial_mode_field = uart_sc_pkg::MODE_BUS;
    {c.tx_allow, c.tx_enable_autoclear, c.collision_en_ch0} = 3'h7;
    d = 8'(rnd());
    c.collision_sample_sel = d[0];
    set_ctrl();
    card_model_i.hold_low <= 1'b1;
    bus(1'b1, uart_sc_pkg::ADDR_TXBUF, 32'hFF);
    wait_req(2, 400);
    card_model_i.hold_low <= 1'b0;
    rd(uart_sc_pkg::ADDR_STAT, 32'h80, 32'h80);
    rd(uart_sc_pkg::ADDR_CTRL, 32'h0, 32'h40);
    bus(1'b1, uart_sc_pkg::ADDR_STAT, 32'h80);
    rd(uart_sc_pkg::ADDR_STAT, 32'h0, 32'h80);
    repeat (4) @(posedge clock);
    stop_test();
  end
endmodule // uart_sc_tb
